// ---- hdl/amr_top.sv ----
// Purpose: selection, reference and result control of the converter
// Assumes: conv_busy, conv_done, conv_code come from core_clk logic
// Notes:   selections written mid-conversion are applied at completion
`timescale 1ns/1ps
`default_nettype none

module amr_top
    import amr_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,

    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,

    // conversion core
    input  wire logic        conv_busy,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_code,

    // analog controls
    output amr_route_s       route,
    output amr_ref_s         ref_ctl,
    output logic             bipolar_mode,

    // interrupt
    output logic             irq
);

    // software-visible registers
    logic [7:0]        chref_ff;
    logic [7:0]        ctrl_b_ff;
    logic [9:0]        result_ff;
    logic [STAT_W-1:0] status_ff;
    logic [STAT_W-1:0] mask_ff;
    logic [31:0]       prdata_ff;

    // applied selection seen by the analog side
    logic [7:0]        active_ff;
    amr_route_s        route_ff;
    amr_ref_s          ref_ff;
    logic              bipolar_ff;

    // conversion tracker
    amr_conv_e         state_ff;
    amr_conv_e         nxt_state;

    // apb decode
    logic              addr_aligned;
    logic [5:0]        addr_idx;
    logic              hit_ctrl_b;
    logic              hit_res_lo;
    logic              hit_res_hi;
    logic              hit_chref;
    logic              hit_status;
    logic              hit_mask;
    logic              addr_mapped;
    logic              setup_rd;
    logic              access;
    logic              wr_en;
    logic [7:0]        wbyte;

    // selection apply path
    logic              apply_now;
    logic              sel_changes;
    amr_route_s        nxt_route;
    amr_ref_s          nxt_ref;
    logic [9:0]        fmt_code;
    logic [31:0]       rd_mux;

    // events into status
    logic [STAT_W-1:0] evt_set;
    logic [STAT_W-1:0] w1c_hit;
    logic [STAT_W-1:0] nxt_status;

    // address decode: registers on aligned words, index = byte addr / 4
    assign addr_aligned = (paddr[1:0] == 2'h0);
    assign addr_idx     = paddr[7:2];
    assign hit_ctrl_b   = addr_aligned && (addr_idx == IDX_CTRL_B);
    assign hit_res_lo   = addr_aligned && (addr_idx == IDX_RESULT_LO);
    assign hit_res_hi   = addr_aligned && (addr_idx == IDX_RESULT_HI);
    assign hit_chref    = addr_aligned && (addr_idx == IDX_CHREF);
    assign hit_status   = addr_aligned && (addr_idx == IDX_STATUS);
    assign hit_mask     = addr_aligned && (addr_idx == IDX_MASK);
    assign addr_mapped  = hit_ctrl_b || hit_res_lo || hit_res_hi ||
                          hit_chref  || hit_status || hit_mask;

    // apb phases; read data is staged in the setup cycle
    assign setup_rd = psel && !penable && !pwrite;
    assign access   = psel && penable;
    assign wr_en    = access && pwrite && addr_mapped;
    assign wbyte    = pwdata[7:0];

    // zero wait states: prdata was already captured at setup
    assign pready  = 1'b1;
    assign pslverr = access && !addr_mapped;
    assign prdata  = prdata_ff;

    // read mux; unused upper bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl_b) begin
            rd_mux[7:0] = ctrl_b_ff;
        end else if (hit_res_lo) begin
            rd_mux[7:0] = result_ff[7:0];
        end else if (hit_res_hi) begin
            rd_mux[1:0] = result_ff[9:8];                          // RULE2
        end else if (hit_chref) begin
            rd_mux[7:0] = chref_ff;
        end else if (hit_status) begin
            rd_mux[STAT_W-1:0] = status_ff;
        end else if (hit_mask) begin
            rd_mux[STAT_W-1:0] = mask_ff;
        end
    end

    // capture read data in the setup cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_ff <= rd_mux;
        end
    end

    // selection register: software view, applied later
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            chref_ff <= CHREF_RST;
        end else if (wr_en && hit_chref) begin
            chref_ff <= wbyte;
        end
    end

    // control b: top bit steers result format, others kept as written
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_b_ff <= CTRL_B_RST;                               // RULE3
        end else if (wr_en && hit_ctrl_b) begin
            ctrl_b_ff <= wbyte;                                    // RULE18
        end
    end

    // mask register, same layout as status
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mask_ff <= '0;
        end else if (wr_en && hit_mask) begin
            mask_ff <= wbyte[STAT_W-1:0];
        end
    end

    // conversion tracker: idle until the core reports busy
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (conv_busy && !conv_done) begin
                    nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // apply only between conversions or on the completing edge,
    // so a mid-conversion write never disturbs the sample in flight
    assign apply_now = ((state_ff == ST_IDLE) && !conv_busy) ||
                       conv_done;                                  // RULE9 RULE10
    assign sel_changes = (active_ff != chref_ff);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            active_ff <= CHREF_RST;
        end else if (apply_now) begin
            active_ff <= chref_ff;                                 // RULE9 RULE10
        end
    end

    // input route decode from the applied selection
    amr_sel_decode u_decode (
        .input_select (active_ff[MUX_MSB:0]),
        .route        (nxt_route)
    );

    // reference decode from the applied selection
    always_comb begin
        nxt_ref = '0;
        case (active_ff[REF_MSB:REF_LSB])
            REF_SUPPLY: begin
                nxt_ref.supply_en = 1'b1;                          // RULE7
            end
            REF_EXTPIN: begin
                nxt_ref.ext_pin_en = 1'b1;                         // RULE7
            end
            REF_INTERN: begin
                nxt_ref.intern_en = 1'b1;                          // RULE7
            end
            REF_TO_PIN: begin
                // pin must be free of external drive in this mode
                nxt_ref.intern_en     = 1'b1;                      // RULE8
                nxt_ref.intern_to_pin = 1'b1;                      // RULE8
            end
            default: begin
                nxt_ref.supply_en = 1'b1;
            end
        endcase
    end

    // registered analog controls: route and reference one cycle behind the apply, bipolar one cycle behind the control b write
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            route_ff   <= '0;
            ref_ff     <= '0;
            bipolar_ff <= 1'b0;
        end else begin
            route_ff   <= nxt_route;
            ref_ff     <= nxt_ref;
            bipolar_ff <= ctrl_b_ff[BIPOLAR_BIT];                  // RULE18
        end
    end

    assign route        = route_ff;
    assign ref_ctl      = ref_ff;
    assign bipolar_mode = bipolar_ff;

    // result formatting uses the route of the finishing conversion
    amr_result_fmt u_fmt (
        .raw_code (conv_code),
        .bipolar  (bipolar_ff),
        .diff     (route_ff.diff),
        .fmt_code (fmt_code)
    );

    // result register updates with the done flag, same edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            result_ff <= RESULT_RST;
        end else if (conv_done) begin
            result_ff <= fmt_code;                                 // RULE1 RULE17
        end
    end

    // events: conversion done, changed selection taken over
    assign evt_set[STAT_DONE]    = conv_done;                      // RULE17
    assign evt_set[STAT_APPLIED] = apply_now && sel_changes;
    assign w1c_hit = (wr_en && hit_status) ? wbyte[STAT_W-1:0]
                                           : '0;

    // sticky bits, cleared by writing one; a new event beats the clear
    genvar gi;
    generate
        for (gi = 0; gi < STAT_W; gi = gi + 1) begin : g_stat
            assign nxt_status[gi] = evt_set[gi] ||
                                    (status_ff[gi] && !w1c_hit[gi]);
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;                               // RULE17
        end
    end

    // level interrupt while any unmasked status bit stands
    assign irq = |(status_ff & mask_ff);

endmodule

`default_nettype wire

// ---- hdl/amr_pkg.sv ----
// Purpose: constants and types for the converter selection control block
// Assumes: APB register access, registers indexed, byte address = 4*index
// Notes:   shared by the top module and its two leaf modules
// How it works
// [RULE1] bipolar result spans 0x200 up to 0x1FF
// [RULE2] bipolar result top bit is the sign
// [RULE3] unipolar by default, bipolar when bit set
// [RULE4] bipolar code is difference*512/reference*gain
// [RULE5] code 100010 routes and enables temperature sensor
// [RULE6] software uses 1.1V reference, single conversion
// [RULE7] reference select decodes supply, pin, internal
// [RULE8] code 11 drives internal reference onto pin
// [RULE9] reference change waits for conversion completion
// [RULE10] input change waits for conversion completion
// [RULE11] software avoids converting during differential settling
// [RULE12] same settling allowance after reference change
// [RULE13] input codes map single, ground, reference, pairs
// [RULE14] lowest bit picks unity or 20x gain
// [RULE15] highest bit swaps pair polarity
// [RULE16] offset calibration ties both inputs together
// [RULE17] done flag set when result updated
// [RULE18] bipolar select is control b bit 7

package amr_pkg;

    // register indices
    localparam logic [5:0] IDX_CTRL_B    = 6'h03;
    localparam logic [5:0] IDX_RESULT_LO = 6'h04;
    localparam logic [5:0] IDX_RESULT_HI = 6'h05;
    localparam logic [5:0] IDX_CHREF     = 6'h07;
    localparam logic [5:0] IDX_STATUS    = 6'h08;
    localparam logic [5:0] IDX_MASK      = 6'h09;

    // field positions
    localparam int unsigned REF_MSB      = 7;
    localparam int unsigned REF_LSB      = 6;
    localparam int unsigned MUX_MSB      = 5;
    localparam int unsigned BIPOLAR_BIT  = 7;
    localparam int unsigned STAT_DONE    = 0;
    localparam int unsigned STAT_APPLIED = 1;
    localparam int unsigned STAT_W       = 2;

    // reset values
    localparam logic [7:0] CHREF_RST  = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;

    // reference codes
    localparam logic [1:0] REF_SUPPLY  = 2'h0;
    localparam logic [1:0] REF_EXTPIN  = 2'h1;
    localparam logic [1:0] REF_INTERN  = 2'h2;
    localparam logic [1:0] REF_TO_PIN  = 2'h3;

    // input selection codes
    localparam logic [5:0] SEL_GND    = 6'h20;
    localparam logic [5:0] SEL_IREF   = 6'h21;
    localparam logic [5:0] SEL_TEMP   = 6'h22;
    localparam logic [5:0] SEL_CAL0   = 6'h23;
    localparam logic [5:0] SEL_CAL3   = 6'h24;
    localparam logic [5:0] SEL_CAL7   = 6'h26;
    localparam logic [3:0] PAIR_BASE  = 4'h4;

    // analog source codes beyond pins 0..7
    localparam logic [3:0] SRC_GND  = 4'h8;
    localparam logic [3:0] SRC_IREF = 4'h9;
    localparam logic [3:0] SRC_TEMP = 4'hA;

    // bipolar result format
    localparam logic [9:0] SIGN_FLIP = 10'h200;
    localparam logic [9:0] MOST_NEG  = 10'h200;
    localparam logic [9:0] MOST_POS  = 10'h1FF;

    // settling advice in converter clocks
    localparam int unsigned SETTLE_MIN_CLKS = 13;
    localparam int unsigned SETTLE_MAX_CLKS = 25;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } amr_conv_e;

    typedef struct packed {
        logic [3:0] pos_src;
        logic [3:0] neg_src;
        logic       diff;
        logic       gain20;
        logic       cal;
        logic       temp_en;
    } amr_route_s;

    typedef struct packed {
        logic supply_en;
        logic ext_pin_en;
        logic intern_en;
        logic intern_to_pin;
    } amr_ref_s;

endpackage

// ---- hdl/amr_sel_decode.sv ----
// Purpose: decode the six-bit input selection into an analog route
// Assumes: purely combinational, fed from the applied selection
// Notes:   reversed pairs reuse the forward pair table, swapped
`timescale 1ns/1ps
`default_nettype none

module amr_sel_decode
    import amr_pkg::*;
(
    // selection in
    input  wire logic [5:0] input_select,
    // route out
    output amr_route_s      route
);

    logic [3:0] pair_idx;
    logic [3:0] pin_a;
    logic [3:0] pin_b;
    logic       is_pair;
    logic       is_cal;
    logic [3:0] cal_pin;

    // forward pair table, first pin positive
    assign pair_idx = input_select[4:1] - PAIR_BASE;
    always_comb begin
        case (pair_idx)
            4'h0:    begin pin_a = 4'h0; pin_b = 4'h1; end
            4'h1:    begin pin_a = 4'h0; pin_b = 4'h3; end
            4'h2:    begin pin_a = 4'h1; pin_b = 4'h2; end
            4'h3:    begin pin_a = 4'h1; pin_b = 4'h3; end
            4'h4:    begin pin_a = 4'h2; pin_b = 4'h3; end
            4'h5:    begin pin_a = 4'h3; pin_b = 4'h4; end
            4'h6:    begin pin_a = 4'h3; pin_b = 4'h5; end
            4'h7:    begin pin_a = 4'h3; pin_b = 4'h6; end
            4'h8:    begin pin_a = 4'h3; pin_b = 4'h7; end
            4'h9:    begin pin_a = 4'h4; pin_b = 4'h5; end
            4'hA:    begin pin_a = 4'h5; pin_b = 4'h6; end
            4'hB:    begin pin_a = 4'h6; pin_b = 4'h7; end
            default: begin pin_a = 4'h0; pin_b = 4'h0; end
        endcase
    end

    // class of the code
    assign is_pair = (input_select[4:3] != 2'h0);                  // RULE13
    assign is_cal  = (input_select >= SEL_CAL0) &&
                     (input_select <= {SEL_CAL7[5:1], 1'b1});      // RULE16
    assign cal_pin = (input_select == SEL_CAL0) ? 4'h0 :
                     (input_select[2:1] == SEL_CAL3[2:1]) ? 4'h3 :
                     4'h7;                                         // RULE16

    // assemble the route
    always_comb begin
        route = '0;
        if (is_pair) begin
            route.diff   = 1'b1;
            route.gain20 = input_select[0];                        // RULE14
            if (input_select[MUX_MSB]) begin                       // RULE15
                route.pos_src = pin_b;
                route.neg_src = pin_a;
            end else begin
                route.pos_src = pin_a;
                route.neg_src = pin_b;
            end
        end else if (is_cal) begin
            route.diff    = 1'b1;
            route.cal     = 1'b1;
            route.gain20  = input_select[0];                       // RULE14
            route.pos_src = cal_pin;                               // RULE16
            route.neg_src = cal_pin;
        end else if (input_select == SEL_GND) begin
            route.pos_src = SRC_GND;                               // RULE13
        end else if (input_select == SEL_IREF) begin
            route.pos_src = SRC_IREF;                              // RULE13
        end else if (input_select == SEL_TEMP) begin
            route.pos_src = SRC_TEMP;                              // RULE5
            route.temp_en = 1'b1;                                  // RULE5
        end else begin
            route.pos_src = {1'b0, input_select[2:0]};             // RULE13
        end
    end

endmodule

`default_nettype wire

// ---- hdl/amr_result_fmt.sv ----
// Purpose: turn the core's raw code into the stored result form
// Assumes: core gives offset binary in bipolar mode, 0x200 = zero
// Notes:   flipping the top bit turns offset binary into two's complement
`timescale 1ns/1ps
`default_nettype none

module amr_result_fmt
    import amr_pkg::*;
(
    // raw result and mode
    input  wire logic [9:0] raw_code,
    input  wire logic       bipolar,
    input  wire logic       diff,
    // formatted result
    output logic [9:0]      fmt_code
);

    logic two_sided;

    // only differential inputs may run two-sided
    assign two_sided = bipolar && diff;                           // RULE3
    assign fmt_code  = two_sided ? (raw_code ^ SIGN_FLIP)         // RULE1 RULE4
                                 : raw_code;                      // RULE2

endmodule

`default_nettype wire

// ---- tb/amr_top_sva.sv ----
// Purpose: port assertions for amr_top
// Assumes: bound to the design top, one clock domain
// Notes:   an idle write reaches the outputs two edges after the write, one after the apply
`timescale 1ns/1ps
`default_nettype none

module amr_top_sva
    import amr_pkg::*;
(
    // clock, reset and apb
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // core and analog controls
    input wire logic        conv_busy,
    input wire logic        conv_done,
    input wire amr_route_s  route,
    input wire amr_ref_s    ref_ctl,
    input wire logic        bipolar_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // a register write, and a selection write with the core quiet
    sequence s_wr(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence s_sel_idle;
        s_wr({IDX_CHREF, 2'b00}) ##0 !conv_busy ##1 !conv_busy;
    endsequence

    AST_TEMP: assert property (
        route.temp_en |-> route.pos_src == SRC_TEMP && !route.diff)
        else $error("temperature route wrong");
    AST_CAL_PIN: assert property (
        route.cal |-> route.pos_src == route.neg_src
            && route.pos_src inside {4'h0, 4'h3, 4'h7})
        else $error("calibration pins wrong");
    AST_SE_SRC: assert property (
        !route.diff && !route.cal |-> route.pos_src <= SRC_TEMP)
        else $error("single ended source out of range");
    AST_REF_PIN: assert property (
        ref_ctl.intern_to_pin |-> ref_ctl.intern_en
            && !ref_ctl.supply_en && !ref_ctl.ext_pin_en)
        else $error("reference to pin decode wrong");
    AST_REF_ONE: assert property (
        $onehot0({ref_ctl.supply_en, ref_ctl.ext_pin_en, ref_ctl.intern_en}))
        else $error("reference sources overlap");
    AST_HOLD: assert property (
        conv_busy && !conv_done |-> ##2 $stable(route) && $stable(ref_ctl))
        else $error("selection changed mid conversion");
    AST_APPLY_TEMP: assert property (
        s_sel_idle |-> ##2 route.temp_en == ($past(pwdata[5:0], 3) == SEL_TEMP))
        else $error("sensor enable not applied");
    AST_APPLY_REF: assert property (
        s_sel_idle |-> ##2 ref_ctl.intern_en == $past(pwdata[7], 3))
        else $error("internal reference not applied");
    AST_BIPOLAR: assert property (
        s_wr({IDX_CTRL_B, 2'b00}) ##1 !(psel && penable)
            |-> ##1 bipolar_mode == $past(pwdata[BIPOLAR_BIT], 2))
        else $error("bipolar mode lags control b");
endmodule
`default_nettype wire

// ---- tb/amr_core_model.sv ----
// Purpose: behavioural conversion core for the amr_top bench
// Assumes: go is a one-cycle command, len at least 1
// Notes:   code bus shows inverted data outside the done cycle
`timescale 1ns/1ps
`default_nettype none

module amr_core_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // command from the bench
    input  wire logic       go,
    input  wire logic [7:0] len,
    input  wire logic [9:0] code_in,
    // core outputs
    output logic            conv_busy,
    output logic            conv_done,
    output logic [9:0]      conv_code
);
    logic [7:0] cnt_ff;
    logic [9:0] code_ff;

    // count the conversion down; a go while busy is ignored
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cnt_ff  <= 8'h00;
            code_ff <= 10'h000;
        end else if (go && cnt_ff == 8'h00) begin
            cnt_ff  <= len;
            code_ff <= code_in;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end

    // done and valid code only in the last busy cycle
    assign conv_busy = (cnt_ff != 8'h00);
    assign conv_done = (cnt_ff == 8'h01);
    assign conv_code = conv_done ? code_ff : ~code_ff;
endmodule
`default_nettype wire

// ---- tb/amr_top_tb.sv ----
// Purpose: self-checking bench for amr_top
// Assumes: zero-wait apb slave, core model paces conversions
// Notes:   expected routes come from a pair table held here
`timescale 1ns/1ps
`default_nettype none

module amr_top_tb
    import amr_pkg::*;
;
    localparam logic [7:0]  A_CB = {IDX_CTRL_B, 2'b00};
    localparam logic [7:0]  A_LO = {IDX_RESULT_LO, 2'b00};
    localparam logic [7:0]  A_HI = {IDX_RESULT_HI, 2'b00};
    localparam logic [7:0]  A_CR = {IDX_CHREF, 2'b00};
    localparam logic [7:0]  A_ST = {IDX_STATUS, 2'b00};
    localparam logic [7:0]  A_MK = {IDX_MASK, 2'b00};
    // forward pairs, pair i in nibble i
    localparam logic [47:0] PP = 48'h654333321100;
    localparam logic [47:0] PN = 48'h765765433231;

    logic        core_clk = 1'b0;
    logic        nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        go = 1'b0, err, pready, pslverr, conv_busy, conv_done;
    logic        irq, bipolar_mode;
    logic [7:0]  paddr = 8'h00, len = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0]  conv_code, code_in = 10'h000;
    logic [23:0] ex;
    amr_route_s  route;
    amr_ref_s    ref_ctl;
    int          ev;
    int          dv [4] = '{-1100, 1098, -50, 30};
    int          gn [4] = '{1, 1, 20, 1};
    int          failures = 0;
    int          n_checks = 0;

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;

    amr_top u_dut (.*);
    amr_core_model u_core (.*);

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer, then one idle edge before the next
    task automatic apb(input logic w, input logic [7:0] a, d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= 32'(d);
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // convert a raw code, read the result back
    task automatic conv_chk(input logic [9:0] raw, e);
        logic [9:0] got;
        go      <= 1'b1;
        len     <= 8'h0D;
        code_in <= raw;
        @(posedge core_clk);
        go      <= 1'b0;
        repeat (14) @(posedge core_clk);
        apb(1'b0, A_LO, 8'h00);
        got[7:0] = rd[7:0];
        apb(1'b0, A_HI, 8'h00);
        got[9:8] = rd[1:0];
        chk("result", 32'(e), 32'(got));
        chk("sign", 32'(e[9]), 32'(rd[1]));
    endtask

    // expected route and mask of checked fields
    function automatic logic [23:0] exp_route(input logic [5:0] c);
        amr_route_s r;
        logic [11:0] m;
        logic [3:0]  p, n, i;
        r = '0;
        m = 12'hFFF;
        i = c[4:1] - 4'h4;
        p = PP[4*i +: 4];
        n = PN[4*i +: 4];
        if (c < 6'h08) begin
            r.pos_src = {1'b0, c[2:0]};
            m = 12'hF0B;
        end else if (c < 6'h20 || c > 6'h27) begin
            r.pos_src = c[5] ? n : p;
            r.neg_src = c[5] ? p : n;
            r.diff    = 1'b1;
            r.gain20  = c[0];
        end else if (c < SEL_CAL0) begin
            r.pos_src = SRC_GND + {2'b00, c[1:0]};
            r.temp_en = (c == SEL_TEMP);
            m = 12'hF0B;
        end else begin
            r.pos_src = (c == SEL_CAL0) ? 4'h0 : (c < SEL_CAL7) ? 4'h3 : 4'h7;
            r.neg_src = r.pos_src;
            r.gain20  = c[0];
            r.cal     = 1'b1;
            m = 12'hFF6;
        end
        return {r, m};
    endfunction

    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, (k < 3) ? A_CB + 8'(4*k) : A_CR + 8'(8*k - 24), 8'h00);
            chk("reset value", 32'h0, rd);
        end
        // read-only result, bad addresses
        apb(1'b1, A_LO, 8'hFF);
        apb(1'b0, A_LO, 8'h00);
        chk("result read only", 32'h0, rd);
        apb(1'b0, 8'h00, 8'h00);
        chk("unmapped error", 32'h1, 32'(err));
        apb(1'b0, A_CR + 8'h01, 8'h00);
        chk("unaligned error", 32'h1, 32'(err));
        // every input code, read back and routed
        for (int c = 0; c < 64; c++) begin
            apb(1'b1, A_CR, {2'b00, 6'(c)});
            apb(1'b0, A_CR, 8'h00);
            chk("selection", 32'(c), rd);
            ex = exp_route(6'(c));
            chk("route", 32'(ex[23:12] & ex[11:0]),
                32'(route & ex[11:0]));
        end
        // every reference code
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, A_CR, {2'(r), SEL_GND});
            repeat (2) @(posedge core_clk);
            chk("reference", (r == 3) ? 32'h3 : 32'h8 >> r,
                32'(ref_ctl));
        end
        // selection written mid conversion waits for done
        apb(1'b1, A_CR, {REF_SUPPLY, 6'h08});
        apb(1'b1, A_ST, 8'h03);
        go      <= 1'b1;
        len     <= 8'h28;
        code_in <= 10'h155;
        @(posedge core_clk);
        go      <= 1'b0;
        apb(1'b1, A_CR, {REF_INTERN, SEL_TEMP});
        repeat (3) @(posedge core_clk);
        chk("held route", 32'h0, 32'(route.temp_en));
        chk("held ref", 32'h8, 32'(ref_ctl));
        apb(1'b0, A_ST, 8'h00);
        chk("status mid run", 32'h0, rd);
        repeat (40) @(posedge core_clk);
        chk("applied route", 32'h1, 32'(route.temp_en));
        chk("applied ref", 32'h2, 32'(ref_ctl));
        apb(1'b0, A_ST, 8'h00);
        chk("status done", 32'h3, rd);
        // interrupt raised, masked and cleared per bit
        chk("irq masked", 32'h0, 32'(irq));
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, A_MK, 8'(1 << b));
            chk("irq set", 32'h1, 32'(irq));
            apb(1'b1, A_ST, 8'(1 << b));
            chk("irq cleared", 32'h0, 32'(irq));
        end
        apb(1'b1, A_MK, 8'h00);
        // bipolar results at the range ends and with gain
        apb(1'b1, A_CB, 8'h80);
        apb(1'b0, A_CB, 8'h00);
        chk("bipolar select", 32'h80, rd);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, A_CR, {REF_INTERN, 5'b00100, gn[k] == 20});
            repeat (25) @(posedge core_clk);
            ev = dv[k] * 512 * gn[k] / 1100;
            conv_chk(10'(ev + 512), 10'(ev));
        end
        apb(1'b1, A_CR, {REF_SUPPLY, 6'h01});
        conv_chk(10'h3FF, 10'h3FF);
        apb(1'b1, A_CB, 8'h00);
        apb(1'b1, A_CR, {REF_SUPPLY, 6'h08});
        repeat (25) @(posedge core_clk);
        conv_chk(10'h3FF, 10'h3FF);
        report_and_stop();
    end

    // watchdog well past the planned run
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        report_and_stop();
    end
endmodule

bind amr_top amr_top_sva u_sva (.*);
`default_nettype wire
